// ### uie_ep0_ctrl.sv
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module uie_ep0_ctrl #(
    parameter int FIFO_W = 4
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // ahb-lite register bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // usb side events
    input wire logic in_token,
    input wire logic setup_received,
    input wire logic global_in_nak_status,
    input wire logic fifo_ready,
    input wire logic xfer_done,
    input wire logic disable_ack,
    // endpoint state to the transfer engine
    output logic endpoint_enable,
    output logic endpoint_disable_request,
    output logic endpoint_nak_status,
    output logic stall,
    output logic [FIFO_W-1:0] tx_fifo_select,
    output logic [6:0] max_packet_bytes,
    // answer to the last in token
    output logic resp_valid,
    output logic resp_stall,
    output logic resp_nak,
    output logic resp_data,
    output logic [FIFO_W-1:0] resp_fifo
);
    // all control register state
    typedef struct packed {
        logic enable; // endpoint_enable
        logic disable_req; // endpoint_disable_request
        logic nak; // endpoint_nak_status
        logic [FIFO_W-1:0] fifo; // tx_fifo_select
        logic stall; // stall handshake request
        logic [1:0] max_packet_length_code; // max_packet_length_code
    } uie_ctl_t;

    uie_ctl_t s;
    uie_ctl_t next_s;
    logic reg_we; // write data phase ends this edge
    logic [31:0] reg_wdata; // write data of that phase
    logic [31:0] rd_view; // word seen by a read
    logic [6:0] next_bytes; // decoded packet length

    // bus slave front end
    uie_ahb_slave u_slave (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hwdata(hwdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .rd_view(rd_view),
        .reg_we(reg_we),
        .reg_wdata(reg_wdata)
    );

    // assemble the read word; fixed and strobe bits are constants
    always_comb begin
        rd_view = 32'h0000_0000;
        rd_view[uie_pkg::EN_BIT] = s.enable;
        rd_view[uie_pkg::DIS_BIT] = s.disable_req;
        // strobes read as zero
        rd_view[uie_pkg::SET_NAK_STROBE_BIT] = 1'b0;
        rd_view[uie_pkg::CLEAR_NAK_STROBE_BIT] = 1'b0;
        rd_view[uie_pkg::FIFO_LSB +: FIFO_W] = s.fifo;
        rd_view[uie_pkg::STALL_BIT] = s.stall;
        rd_view[uie_pkg::TYPE_LSB +: 2] = uie_pkg::TYPE_CTRL;
        rd_view[uie_pkg::NAK_BIT] = s.nak;
        rd_view[uie_pkg::ACT_BIT] = uie_pkg::ACT_FIXED;
        rd_view[uie_pkg::MPL_LSB +: 2] = s.max_packet_length_code;
    end

    // next register state; software sets win over hardware clears
    always_comb begin
        next_s = s;
        // hardware clears first, so a same-cycle set overrides
        if (xfer_done || disable_ack) begin
            next_s.enable = 1'b0;
        end
        if (disable_ack) begin
            next_s.disable_req = 1'b0;
        end
        if (setup_received) begin
            next_s.stall = 1'b0;
        end
        if (reg_we) begin
            // set-only bits: a zero write leaves them alone
            if (reg_wdata[uie_pkg::EN_BIT]) begin
                next_s.enable = 1'b1;
            end
            if (reg_wdata[uie_pkg::DIS_BIT]) begin
                next_s.disable_req = 1'b1;
            end
            if (reg_wdata[uie_pkg::STALL_BIT]) begin
                next_s.stall = 1'b1;
            end
            // nak moves only by strobes; set wins if both
            if (reg_wdata[uie_pkg::SET_NAK_STROBE_BIT]) begin
                next_s.nak = 1'b1;
            end else if (reg_wdata[uie_pkg::CLEAR_NAK_STROBE_BIT]) begin
                next_s.nak = 1'b0;
            end
            // plain read-write fields
            next_s.fifo = reg_wdata[uie_pkg::FIFO_LSB +: FIFO_W];
            next_s.max_packet_length_code = reg_wdata[uie_pkg::MPL_LSB +: 2];
        end
    end

    // state register; reset leaves only the active bit visible
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{enable: 1'b0, disable_req: 1'b0, nak: 1'b0,
                   fifo: FIFO_W'(uie_pkg::FIFO_RST), stall: 1'b0,
                   max_packet_length_code: uie_pkg::MPL_RST};
        end else begin
            s <= next_s;
        end
    end

    // packet length code to byte count
    always_comb begin
        unique case (s.max_packet_length_code)
            uie_pkg::MPL_64: next_bytes = uie_pkg::BYTES_64;
            uie_pkg::MPL_32: next_bytes = uie_pkg::BYTES_32;
            uie_pkg::MPL_16: next_bytes = uie_pkg::BYTES_16;
            uie_pkg::MPL_8: next_bytes = uie_pkg::BYTES_8;
        endcase
    end

    // in token answer logic
    uie_in_responder #(
        .FIFO_W(FIFO_W)
    ) u_resp (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_token(in_token),
        .enable(s.enable),
        .stall(s.stall),
        .nak(s.nak),
        .global_in_nak_status(global_in_nak_status),
        .fifo_ready(fifo_ready),
        .fifo_sel(s.fifo),
        .resp_valid(resp_valid),
        .resp_stall(resp_stall),
        .resp_nak(resp_nak),
        .resp_data(resp_data),
        .resp_fifo(resp_fifo)
    );

    // state straight from flip-flops; byte count decoded from the length code
    assign endpoint_enable = s.enable;
    assign endpoint_disable_request = s.disable_req;
    assign endpoint_nak_status = s.nak;
    assign stall = s.stall;
    assign tx_fifo_select = s.fifo;
    assign max_packet_bytes = next_bytes;

    // software write of enable shows on endpoint_enable one cycle later
    property p_en_set;
        @(posedge sys_clk) disable iff (!rst_n)
        (reg_we && reg_wdata[uie_pkg::EN_BIT]) |=> endpoint_enable;
    endproperty
    a_en_set: assert property (p_en_set)
        else $error("enable write lost");

    // enable falls only on a hardware clear
    property p_en_clr;
        @(posedge sys_clk) disable iff (!rst_n)
        $fell(endpoint_enable) |-> $past(xfer_done || disable_ack);
    endproperty
    a_en_clr: assert property (p_en_clr)
        else $error("enable cleared without cause");

    // disable write raises the request until acknowledged
    property p_dis_req;
        @(posedge sys_clk) disable iff (!rst_n)
        (reg_we && reg_wdata[uie_pkg::DIS_BIT])
            |=> endpoint_disable_request;
    endproperty
    a_dis_req: assert property (p_dis_req)
        else $error("disable request not raised");

    // set-nak strobe
    property p_set_nak_strobe;
        @(posedge sys_clk) disable iff (!rst_n)
        (reg_we && reg_wdata[uie_pkg::SET_NAK_STROBE_BIT])
            |=> endpoint_nak_status;
    endproperty
    a_set_nak_strobe: assert property (p_set_nak_strobe)
        else $error("set nak ignored");

    // clear-nak strobe
    property p_clear_nak_strobe;
        @(posedge sys_clk) disable iff (!rst_n)
        (reg_we && reg_wdata[uie_pkg::CLEAR_NAK_STROBE_BIT] &&
         !reg_wdata[uie_pkg::SET_NAK_STROBE_BIT]) |=> !endpoint_nak_status;
    endproperty
    a_clear_nak_strobe: assert property (p_clear_nak_strobe)
        else $error("clear nak ignored");

    // nak status holds without a bus write
    property p_nak_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        !reg_we |=> $stable(endpoint_nak_status);
    endproperty
    a_nak_hold: assert property (p_nak_hold)
        else $error("nak status moved by itself");

    // setup clears stall unless software sets it again
    property p_stall_clr;
        @(posedge sys_clk) disable iff (!rst_n)
        (setup_received && !(reg_we && reg_wdata[uie_pkg::STALL_BIT]))
            |=> !stall;
    endproperty
    a_stall_clr: assert property (p_stall_clr)
        else $error("setup left stall set");

    // a read of the register shows fixed type and active bits
    property p_rd_fixed;
        @(posedge sys_clk) disable iff (!rst_n)
        (hsel && htrans[1] && hready && !hwrite &&
         hsize == uie_pkg::HSIZE_WORD &&
         haddr[11:0] == uie_pkg::CTRL_OFS)
            |=> (hrdata[uie_pkg::ACT_BIT] &&
                 hrdata[uie_pkg::TYPE_LSB +: 2] == uie_pkg::TYPE_CTRL &&
                 !hrdata[uie_pkg::SET_NAK_STROBE_BIT] && !hrdata[uie_pkg::CLEAR_NAK_STROBE_BIT]);
    endproperty
    a_rd_fixed: assert property (p_rd_fixed)
        else $error("fixed bits read wrong");

    // packet length follows a write of the 8 byte code
    property p_mpl;
        @(posedge sys_clk) disable iff (!rst_n)
        (reg_we && reg_wdata[1:0] == uie_pkg::MPL_8)
            |=> (max_packet_bytes == uie_pkg::BYTES_8);
    endproperty
    a_mpl: assert property (p_mpl)
        else $error("packet length wrong");

    // stall falls only when a setup token arrives
    property p_stall_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        $fell(stall) |-> $past(setup_received);
    endproperty
    a_stall_hold: assert property (p_stall_hold)
        else $error("stall cleared without setup");

    // disable request falls only on the acknowledge
    property p_dis_clr;
        @(posedge sys_clk) disable iff (!rst_n)
        $fell(endpoint_disable_request) |-> $past(disable_ack);
    endproperty
    a_dis_clr: assert property (p_dis_clr)
        else $error("disable request dropped early");

    // a register write lands in the fifo select field
    property p_fifo_wr;
        @(posedge sys_clk) disable iff (!rst_n)
        reg_we |=> (tx_fifo_select ==
                    $past(reg_wdata[uie_pkg::FIFO_LSB +: FIFO_W]));
    endproperty
    a_fifo_wr: assert property (p_fifo_wr)
        else $error("fifo select write lost");

    // global nak alone still refuses data
    property p_gnak;
        @(posedge sys_clk) disable iff (!rst_n)
        (in_token && !stall && global_in_nak_status)
            |=> (resp_nak && !resp_data);
    endproperty
    a_gnak: assert property (p_gnak)
        else $error("global nak ignored");
endmodule

// ### uie_pkg.sv
package uie_pkg;
    // register placement (low address bits decoded)
    localparam logic [11:0] CTRL_OFS = 12'h900;
    localparam logic [31:0] CTRL_RST = 32'h0000_8000;
    // field positions inside the control word
    localparam int EN_BIT = 31;
    localparam int DIS_BIT = 30;
    localparam int SET_NAK_STROBE_BIT = 27;
    localparam int CLEAR_NAK_STROBE_BIT = 26;
    localparam int FIFO_LSB = 22;
    localparam int STALL_BIT = 21;
    localparam int TYPE_LSB = 18;
    localparam int NAK_BIT = 17;
    localparam int ACT_BIT = 15;
    localparam int MPL_LSB = 0;
    // fixed and reset field values
    localparam logic [1:0] TYPE_CTRL = 2'h0;
    localparam logic ACT_FIXED = 1'h1;
    localparam logic [3:0] FIFO_RST = 4'h0;
    localparam logic [1:0] MPL_RST = 2'h0;
    // packet length codes and their byte counts
    localparam logic [1:0] MPL_64 = 2'h0;
    localparam logic [1:0] MPL_32 = 2'h1;
    localparam logic [1:0] MPL_16 = 2'h2;
    localparam logic [1:0] MPL_8 = 2'h3;
    localparam logic [6:0] BYTES_64 = 7'h40;
    localparam logic [6:0] BYTES_32 = 7'h20;
    localparam logic [6:0] BYTES_16 = 7'h10;
    localparam logic [6:0] BYTES_8 = 7'h08;
    // bus encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // answer to an IN token, gray ordered
    typedef enum logic [1:0] {
        UIE_RESP_NONE = 2'h0,
        UIE_RESP_DATA = 2'h1,
        UIE_RESP_NAK = 2'h3,
        UIE_RESP_STALL = 2'h2
    } uie_resp_t;
endpackage

// ### uie_ahb_slave.sv
`timescale 1ns/1ps
module uie_ahb_slave (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // ahb-lite slave side
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // register side
    input wire logic [31:0] rd_view,
    output logic reg_we,
    output logic [31:0] reg_wdata
);
    // all slave state
    typedef struct packed {
        logic wr_pend;
        logic [31:0] rdata;
    } uie_slv_t;

    uie_slv_t s;
    uie_slv_t next_s;
    logic accept; // address phase taken this edge
    logic hit; // word access to the control register

    // decode the address phase, capture read data at once
    always_comb begin
        next_s = s;
        accept = hsel && htrans[1] && hready;
        hit = (haddr[11:0] == uie_pkg::CTRL_OFS) &&
              (hsize == uie_pkg::HSIZE_WORD);
        next_s.wr_pend = accept && hwrite && hit;
        if (accept && !hwrite) begin
            // unmapped or narrow reads return zero
            next_s.rdata = hit ? rd_view : 32'h0000_0000;
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // never waits, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s.rdata;
    assign reg_we = s.wr_pend;
    assign reg_wdata = hwdata;
endmodule

// ### uie_in_responder.sv
`timescale 1ns/1ps
module uie_in_responder #(
    parameter int FIFO_W = 4
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // token and endpoint state
    input wire logic in_token,
    input wire logic enable,
    input wire logic stall,
    input wire logic nak,
    input wire logic global_in_nak_status,
    input wire logic fifo_ready,
    input wire logic [FIFO_W-1:0] fifo_sel,
    // registered answer
    output logic resp_valid,
    output logic resp_stall,
    output logic resp_nak,
    output logic resp_data,
    output logic [FIFO_W-1:0] resp_fifo
);
    // all responder state
    typedef struct packed {
        uie_pkg::uie_resp_t kind;
        logic [FIFO_W-1:0] fifo;
    } uie_rsp_t;

    uie_rsp_t s;
    uie_rsp_t next_s;

    // pick the answer; stall beats every nak source
    always_comb begin
        next_s = s;
        next_s.kind = uie_pkg::UIE_RESP_NONE;
        if (in_token) begin
            next_s.fifo = fifo_sel;
            if (stall) begin
                next_s.kind = uie_pkg::UIE_RESP_STALL;
            end else if (global_in_nak_status || nak) begin
                next_s.kind = uie_pkg::UIE_RESP_NAK;
            end else if (enable && fifo_ready) begin
                next_s.kind = uie_pkg::UIE_RESP_DATA;
            end else begin
                next_s.kind = uie_pkg::UIE_RESP_NAK;
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // one-cycle answer pulses
    assign resp_valid = (s.kind != uie_pkg::UIE_RESP_NONE);
    assign resp_stall = (s.kind == uie_pkg::UIE_RESP_STALL);
    assign resp_nak = (s.kind == uie_pkg::UIE_RESP_NAK);
    assign resp_data = (s.kind == uie_pkg::UIE_RESP_DATA);
    assign resp_fifo = s.fifo;

    // stall answers every token while set
    property p_stall_ans;
        @(posedge sys_clk) disable iff (!rst_n)
        (in_token && stall) |=> resp_stall;
    endproperty
    a_stall_ans: assert property (p_stall_ans)
        else $error("stall not answered");

    // stall wins over both nak sources
    property p_stall_prio;
        @(posedge sys_clk) disable iff (!rst_n)
        (in_token && stall && (nak || global_in_nak_status))
            |=> (resp_stall && !resp_nak);
    endproperty
    a_stall_prio: assert property (p_stall_prio)
        else $error("nak beat stall");

    // nak status forces nak when stall clear
    property p_nak_ans;
        @(posedge sys_clk) disable iff (!rst_n)
        (in_token && !stall && nak) |=> (resp_nak && !resp_data);
    endproperty
    a_nak_ans: assert property (p_nak_ans)
        else $error("nak status ignored");

    // data goes out from the selected fifo
    property p_fifo_sel;
        @(posedge sys_clk) disable iff (!rst_n)
        resp_data |-> (resp_fifo == $past(fifo_sel));
    endproperty
    a_fifo_sel: assert property (p_fifo_sel)
        else $error("wrong fifo answered");
endmodule

// ### uie_host_model.sv
`timescale 1ns/1ps
// usb host side: token pulses, fifo and global nak levels
module uie_host_model (
    // clock
    input wire logic sys_clk,
    // token and event pulses
    output logic in_token,
    output logic setup_received,
    output logic xfer_done,
    output logic disable_ack,
    // levels seen by the endpoint
    output logic fifo_ready,
    output logic global_in_nak_status
);
    // quiet bus at time zero
    initial begin
        in_token = 1'b0;
        setup_received = 1'b0;
        xfer_done = 1'b0;
        disable_ack = 1'b0;
        fifo_ready = 1'b0;
        global_in_nak_status = 1'b0;
    end
    // in tokens on n consecutive cycles
    task automatic tok(input int n);
        @(posedge sys_clk);
        in_token <= 1'b1;
        repeat (n) @(posedge sys_clk);
        in_token <= 1'b0;
    endtask
    // one-cycle event: 0 setup, 1 transfer done, 2 disable done
    task automatic ev(input int k);
        @(posedge sys_clk);
        setup_received <= (k == 0);
        xfer_done <= (k == 1);
        disable_ack <= (k == 2);
        @(posedge sys_clk);
        setup_received <= 1'b0;
        xfer_done <= 1'b0;
        disable_ack <= 1'b0;
    endtask
    // packet waiting and global nak levels
    task automatic lv(input logic fr, input logic gn);
        @(posedge sys_clk);
        fifo_ready <= fr;
        global_in_nak_status <= gn;
    endtask
endmodule

// ### uie_ep0_ctrl_tb.sv
`timescale 1ns/1ps
// self-checking bench for the in endpoint 0 control block
module uie_ep0_ctrl_tb;
    // write bits of the control word
    localparam logic [31:0] B_EN = 32'h8000_0000;
    localparam logic [31:0] B_DIS = 32'h4000_0000;
    localparam logic [31:0] B_SN = 32'h0800_0000;
    localparam logic [31:0] B_CN = 32'h0400_0000;
    localparam logic [31:0] B_ST = 32'h0020_0000;
    localparam logic [31:0] B_NK = 32'h0002_0000;
    localparam logic [31:0] A_CTL = 32'h0000_0900;
    // clock, reset and bus master
    logic sys_clk;
    logic rst_n;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    // usb side nets
    logic in_token, setup_received, xfer_done, disable_ack;
    logic fifo_ready, global_in_nak_status;
    // endpoint state and answer
    logic endpoint_enable, endpoint_disable_request, endpoint_nak_status;
    logic stall, resp_valid, resp_stall, resp_nak, resp_data;
    logic [3:0] tx_fifo_select, resp_fifo;
    logic [6:0] max_packet_bytes;
    // mirror of register fields and host levels
    logic m_en, m_dis, m_nak, m_stall, m_fr, m_gn;
    logic [3:0] m_fifo;
    logic [1:0] m_mpl;
    logic [15:0] lfsr;
    // expected results, counters, read data phase flag
    logic [31:0] q_rd[$];
    logic [6:0] q_resp[$];
    int n_errors;
    int checked;
    logic rd_dph = 1'b0;

    // device under test; the one slave drives hready
    uie_ep0_ctrl #(.FIFO_W(4)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .in_token(in_token), .setup_received(setup_received),
        .global_in_nak_status(global_in_nak_status),
        .fifo_ready(fifo_ready), .xfer_done(xfer_done),
        .disable_ack(disable_ack), .endpoint_enable(endpoint_enable),
        .endpoint_disable_request(endpoint_disable_request),
        .endpoint_nak_status(endpoint_nak_status), .stall(stall),
        .tx_fifo_select(tx_fifo_select),
        .max_packet_bytes(max_packet_bytes), .resp_valid(resp_valid),
        .resp_stall(resp_stall), .resp_nak(resp_nak),
        .resp_data(resp_data), .resp_fifo(resp_fifo));
    // host model on the usb side
    uie_host_model u_host (.sys_clk(sys_clk), .in_token(in_token),
        .setup_received(setup_received), .xfer_done(xfer_done),
        .disable_ack(disable_ack), .fifo_ready(fifo_ready),
        .global_in_nak_status(global_in_nak_status));

    // 25 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // next pseudo random word
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // write word: fifo and length fields, type written as 11, active 0
    function automatic logic [31:0] fld(input logic [3:0] f,
        input logic [1:0] m, input logic [31:0] bits);
        logic [31:0] r;
        r = bits;
        r[uie_pkg::FIFO_LSB +: 4] = f;
        r[uie_pkg::MPL_LSB +: 2] = m;
        r[uie_pkg::TYPE_LSB +: 2] = 2'h3;
        return r;
    endfunction
    // expected read value from the mirror
    function automatic logic [31:0] reg_exp();
        logic [31:0] r;
        r = fld(m_fifo, m_mpl, 32'h0);
        r[uie_pkg::TYPE_LSB +: 2] = uie_pkg::TYPE_CTRL;
        r[uie_pkg::EN_BIT] = m_en;
        r[uie_pkg::DIS_BIT] = m_dis;
        r[uie_pkg::STALL_BIT] = m_stall;
        r[uie_pkg::NAK_BIT] = m_nak;
        r[uie_pkg::ACT_BIT] = uie_pkg::ACT_FIXED;
        return r;
    endfunction
    // expected answer {stall, nak, data, fifo}, stall first
    function automatic logic [6:0] resp_exp();
        if (m_stall) return {3'h4, m_fifo};
        if (m_gn || m_nak) return {3'h2, m_fifo};
        if (m_en && m_fr) return {3'h1, m_fifo};
        return {3'h2, m_fifo};
    endfunction
    // expected levels {enable, disable, nak, stall, fifo, bytes}
    function automatic logic [14:0] lvl_exp();
        logic [6:0] b;
        case (m_mpl)
            uie_pkg::MPL_64: b = uie_pkg::BYTES_64;
            uie_pkg::MPL_32: b = uie_pkg::BYTES_32;
            uie_pkg::MPL_16: b = uie_pkg::BYTES_16;
            default: b = uie_pkg::BYTES_8;
        endcase
        return {m_en, m_dis, m_nak, m_stall, m_fifo, b};
    endfunction
    // one mismatch report
    task automatic fail(input string s);
        n_errors++;
        $display("CHECK FAILED %0t %s", $time, s);
    endtask
    // compare tasks, one per kind of result
    task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) fail($sformatf("read %h want %h", g, e));
    endtask
    task automatic cmp_resp(input logic [6:0] g, input logic [6:0] e);
        checked++;
        if (g !== e) fail($sformatf("answer %h want %h", g, e));
    endtask
    task automatic cmp_lvl(input logic [14:0] g, input logic [14:0] e);
        checked++;
        if (g !== e) fail($sformatf("levels %h want %h", g, e));
    endtask
    // bounded wait for hready at a rising edge
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 16);
        if (hreadyout !== 1'b1) begin
            fail("bus wait expired");
            print_verdict();
        end
    endtask
    // one ahb-lite single word transfer
    task automatic xfer(input logic [31:0] a, input logic w,
        input logic [31:0] d);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= uie_pkg::HSIZE_WORD;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        cmp_word({31'h0, hresp}, 32'h0); // okay response
    endtask
    // register write, mirror follows the write effects
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
        if (a[11:0] == uie_pkg::CTRL_OFS) begin
            m_en = m_en | d[uie_pkg::EN_BIT];
            m_dis = m_dis | d[uie_pkg::DIS_BIT];
            m_stall = m_stall | d[uie_pkg::STALL_BIT];
            if (d[uie_pkg::SET_NAK_STROBE_BIT]) m_nak = 1'b1;
            else if (d[uie_pkg::CLEAR_NAK_STROBE_BIT]) m_nak = 1'b0;
            m_fifo = d[uie_pkg::FIFO_LSB +: 4];
            m_mpl = d[uie_pkg::MPL_LSB +: 2];
        end
    endtask
    // register read, expectation noted for the monitor
    task automatic rd(input logic [31:0] a);
        q_rd.push_back(a[11:0] == uie_pkg::CTRL_OFS ? reg_exp() : 32'h0);
        xfer(a, 1'b0, 32'h0);
    endtask
    // read the control word, then compare the level outputs
    task automatic chk();
        rd(A_CTL);
        #1;
        cmp_lvl({endpoint_enable, endpoint_disable_request,
            endpoint_nak_status, stall, tx_fifo_select,
            max_packet_bytes}, lvl_exp());
    endtask
    // n back-to-back in tokens with noted answers
    task automatic in_n(input int n);
        repeat (n) q_resp.push_back(resp_exp());
        u_host.tok(n);
    endtask
    // host event and level changes, mirrored
    task automatic host_ev(input int k);
        u_host.ev(k);
        if (k == 0) m_stall = 1'b0;
        if (k != 0) m_en = 1'b0;
        if (k == 2) m_dis = 1'b0;
    endtask
    task automatic host_lv(input logic fr, input logic gn);
        u_host.lv(fr, gn);
        m_fr = fr;
        m_gn = gn;
    endtask
    // closing report
    task automatic print_verdict();
        $display("counts: %0d checked, %0d errors", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // monitor: read data at the data phase edge, answers when valid
    always @(posedge sys_clk) begin
        if (rd_dph && hreadyout === 1'b1)
            cmp_word(hrdata, q_rd.pop_front());
        rd_dph = hsel && htrans[1] && !hwrite && hreadyout === 1'b1;
        if (resp_valid === 1'b1) cmp_resp({resp_stall, resp_nak,
            resp_data, resp_fifo},
            q_resp.size() ? q_resp.pop_front() : 7'h7F);
    end
    // hang guard
    initial begin
        #400000;
        fail("run time expired");
        print_verdict();
    end
    // main sequence
    initial begin
        {rst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = uie_pkg::HSIZE_WORD;
        {m_en, m_dis, m_nak, m_stall, m_fr, m_gn, m_fifo, m_mpl} = '0;
        lfsr = 16'hE6A3;
        n_errors = 0;
        checked = 0;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        chk();
        $display("test reset value done");
        for (int c = 0; c < 4; c++) begin
            lfsr = lfsr_next(lfsr);
            wr(A_CTL, fld(lfsr[3:0], c[1:0], 32'h0));
            chk();
        end
        $display("test fifo and length fields done");
        wr(A_CTL, fld(m_fifo, m_mpl, B_SN));
        chk();
        in_n(1);
        wr(A_CTL, fld(m_fifo, m_mpl, B_CN));
        chk();
        wr(A_CTL, fld(m_fifo, m_mpl, B_NK));
        chk();
        wr(A_CTL, fld(m_fifo, m_mpl, B_SN | B_CN));
        chk();
        $display("test nak strobes done");
        host_lv(1'b1, 1'b0);
        wr(A_CTL, fld(m_fifo, m_mpl, B_EN | B_CN));
        chk();
        in_n(2);
        host_lv(1'b1, 1'b1);
        in_n(1);
        host_lv(1'b1, 1'b0);
        host_ev(1);
        chk();
        in_n(1);
        $display("test enable and data answers done");
        wr(A_CTL, fld(m_fifo, m_mpl, B_EN));
        wr(A_CTL, fld(m_fifo, m_mpl, B_DIS));
        chk();
        host_ev(2);
        chk();
        $display("test disable done");
        wr(A_CTL, fld(m_fifo, m_mpl, B_EN | B_ST | B_SN));
        host_lv(1'b1, 1'b1);
        in_n(3);
        wr(A_CTL, fld(m_fifo, m_mpl, 32'h0));
        chk();
        host_ev(0);
        chk();
        in_n(1);
        $display("test stall done");
        wr(32'h0000_0904, 32'hFFFF_FFFF);
        rd(32'h0000_0904);
        chk();
        $display("test unmapped place done");
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        {m_en, m_dis, m_nak, m_stall} = '0;
        m_fifo = uie_pkg::FIFO_RST;
        m_mpl = uie_pkg::MPL_RST;
        chk();
        $display("test reset in mid run done");
        repeat (4) @(posedge sys_clk);
        if (q_resp.size() != 0 || q_rd.size() != 0) fail("missing result");
        print_verdict();
    end
endmodule
